// >>> verilog/lcdfr_pkg.sv
/*
 * Package for the panel frame rate divider: register map, field positions,
 * reset values, duty codes and divider constants.
 * Assumes a single 250 MHz system clock domain and an APB register port.
 */
package lcdfr_pkg;

	// ==========================================================
	// register map
	localparam logic [11:0] FRR_IDX         = 12'h0e6;
	localparam logic [11:0] FRR_ADDR        = FRR_IDX << 2;
	localparam logic [11:0] CTRL_ADDR       = 12'h39c;
	localparam logic [11:0] STAT_ADDR       = 12'h3a0;
	localparam logic [7:0]  FRR_RESET       = 8'h00;
	localparam logic [7:0]  FRR_WMASK       = 8'h77;
	localparam int          PS_LSB          = 4;
	localparam int          CD_LSB          = 0;
	localparam int          CTRL_CS_BIT     = 0;
	localparam int          CTRL_DUTY_LSB   = 1;
	localparam logic [2:0]  CTRL_RESET      = 3'h0;

	// ==========================================================
	// duty codes and frame factors
	typedef enum logic [1:0]
	{
		DUTY_STATIC  = 2'h0,
		DUTY_HALF    = 2'h1,
		DUTY_THIRD   = 2'h2,
		DUTY_QUARTER = 2'h3
	} lcdfr_duty_t;

	localparam logic [3:0] K_NORMAL = 4'h8;
	localparam logic [3:0] K_THIRD  = 4'h6;

	// ==========================================================
	// frame rate configuration carrier
	typedef struct packed
	{
		logic [2:0] prescalerTapSelect;
		logic [2:0] frameClockDivide;
	} lcdfr_cfg_t;

	// ==========================================================
	// apb request carrier
	typedef struct packed
	{
		logic        sel;
		logic        enable;
		logic        write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} lcdfr_apb_t;

endpackage

// >>> verilog/lcdfr_frame_divider.sv
/*
 * Panel frame rate divider: APB register slave, clock source choice,
 * tap prescaler, 1..8 clock divider and frame-start pulse generation.
 * Assumes the asynchronous oscillator arrives as a pin and is sampled
 * in the system clock domain; its rate must be well below sys_clk / 2.
 */
// Overview of operation
// (RL1) Bits 7 and 3 of the frame rate register read as zero and do nothing.
// (RL2) Bits 6:4 pick prescaler divisor N of 16,64,128,256,512,1024,2048,4096.
// (RL3) The prescaler tap feeds a divider whose output is the prescaled clock.
// (RL4) Bits 2:0 set divider ratio D to the field value plus one.
// (RL5) Frame rate is input clock over K*N*D, K being 8 for static,1/2,1/4.
// (RL6) With one-third duty a frame spans 6*N*D input clock cycles.
// (RL7) Source select zero uses the system clock, one the external clock.
// (RL8) Duty select 00 static, 01 half, 10 third, 11 quarter sets K.
// (RL9) Free-running counters give a frame-start pulse every K*N*D ticks.
module lcdfr_frame_divider
	import lcdfr_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        extClock,
	output logic             prescaledPanelClock,
	output logic             frameStart
);

	// ==========================================================
	// functions
	function automatic logic [11:0] tapMax(input logic [2:0] sel);
		case (sel)
			3'h0:    tapMax = 12'h00f;
			3'h1:    tapMax = 12'h03f;
			3'h2:    tapMax = 12'h07f;
			3'h3:    tapMax = 12'h0ff;
			3'h4:    tapMax = 12'h1ff;
			3'h5:    tapMax = 12'h3ff;
			3'h6:    tapMax = 12'h7ff;
			default: tapMax = 12'hfff;
		endcase
	endfunction

	function automatic logic [3:0] kFactor(input lcdfr_duty_t duty);
		kFactor = (duty == DUTY_THIRD) ? K_THIRD : K_NORMAL;
	endfunction

	// ==========================================================
	// registers and bus
	lcdfr_cfg_t  cfg_r;
	logic        panelClockSourceSelect_r;
	lcdfr_duty_t dutySelect_r;
	lcdfr_apb_t  req;
	logic        access;
	logic        mapped;
	logic [31:0] rdata_nxt;

	assign req.sel    = psel;
	assign req.enable = penable;
	assign req.write  = pwrite;
	assign req.addr   = paddr;
	assign req.wdata  = pwdata;
	assign access = req.sel && req.enable;
	assign mapped = (req.addr == FRR_ADDR) || (req.addr == CTRL_ADDR)
		|| (req.addr == STAT_ADDR);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_r.prescalerTapSelect <= FRR_RESET[PS_LSB +: 3];
			cfg_r.frameClockDivide   <= FRR_RESET[CD_LSB +: 3];
		end
		else if (access && pready && req.write && req.addr == FRR_ADDR)
		begin
			cfg_r.prescalerTapSelect <= req.wdata[PS_LSB +: 3]; // [RL2]
			cfg_r.frameClockDivide   <= req.wdata[CD_LSB +: 3]; // [RL4]
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			panelClockSourceSelect_r <= CTRL_RESET[CTRL_CS_BIT];
			dutySelect_r             <= DUTY_STATIC;
		end
		else if (access && pready && req.write && req.addr == CTRL_ADDR)
		begin
			panelClockSourceSelect_r <= req.wdata[CTRL_CS_BIT];
			dutySelect_r <= lcdfr_duty_t'(req.wdata[CTRL_DUTY_LSB +: 2]);
		end
	end

	// ==========================================================
	// source select and tap prescaler
	logic        extSync1_r;
	logic        extSync2_r;
	logic        extPrev_r;
	logic        panelTick;
	logic [11:0] prescaleCnt_r;
	logic        tapTick;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			extSync1_r <= 1'b0;
			extSync2_r <= 1'b0;
			extPrev_r  <= 1'b0;
		end
		else
		begin
			extSync1_r <= extClock;
			extSync2_r <= extSync1_r;
			extPrev_r  <= extSync2_r;
		end
	end

	// one tick per panel input clock period
	assign panelTick = panelClockSourceSelect_r ?
		(extSync2_r && !extPrev_r) : 1'b1; // [RL7]
	assign tapTick = panelTick
		&& (prescaleCnt_r >= tapMax(cfg_r.prescalerTapSelect)); // [RL2]

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			prescaleCnt_r <= 12'h000;
		else if (tapTick)
			prescaleCnt_r <= 12'h000; // [RL9]
		else if (panelTick)
			prescaleCnt_r <= prescaleCnt_r + 12'h001;
	end

	// ==========================================================
	// clock divider and frame counter
	logic [2:0] divCnt_r;
	logic       psTick;
	logic [3:0] frameCnt_r;

	assign psTick = tapTick
		&& (divCnt_r >= cfg_r.frameClockDivide); // [RL4] [RL3]

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			divCnt_r <= 3'h0;
		else if (psTick)
			divCnt_r <= 3'h0;
		else if (tapTick)
			divCnt_r <= divCnt_r + 3'h1;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			prescaledPanelClock <= 1'b0;
		else if (psTick)
			prescaledPanelClock <= !prescaledPanelClock; // [RL3]
	end

	// frame = K prescaled ticks, K from duty
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			frameCnt_r <= 4'h0;
			frameStart <= 1'b0;
		end
		else
		begin
			frameStart <= 1'b0;
			if (psTick)
			begin
				if (frameCnt_r >= kFactor(dutySelect_r) - 4'h1) // [RL5] [RL6] [RL8]
				begin
					frameCnt_r <= 4'h0;
					frameStart <= 1'b1; // [RL9]
				end
				else
					frameCnt_r <= frameCnt_r + 4'h1;
			end
		end
	end

	// ==========================================================
	// read data and bus answer
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		case (req.addr)
			FRR_ADDR:
				rdata_nxt[7:0] = {1'b0, cfg_r.prescalerTapSelect, 1'b0,
					cfg_r.frameClockDivide}; // [RL1]
			CTRL_ADDR:
				rdata_nxt[2:0] = {dutySelect_r, panelClockSourceSelect_r};
			STAT_ADDR:
				rdata_nxt[4:0] = {prescaledPanelClock, frameCnt_r};
			default:
				rdata_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= req.sel && !req.enable;
			prdata  <= rdata_nxt;
			pslverr <= req.sel && !req.enable && !mapped;
		end
	end

endmodule

// >>> tb/lcdfr_frame_divider_monitor.sv
/* APB and frame pulse checker for the frame divider.
   Assumes one sys_clk domain; bound to the divider below. */
module lcdfr_frame_divider_monitor
	import lcdfr_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        frameStart
);
	timeunit 1ns;
	timeprecision 1ps;
	logic mapped;
	logic rdDone;
	assign mapped = paddr == FRR_ADDR || paddr == CTRL_ADDR
		|| paddr == STAT_ADDR;
	assign rdDone = pready && !pwrite;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// assertions
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready in access phase");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_unmapped: assert property (pready && !mapped |-> pslverr)
		else $error("no error on unmapped address");
	a_err_mapped_ok: assert property (pready && mapped |-> !pslverr)
		else $error("error on mapped address");
	a_reserved_zero: assert property (
		rdDone && paddr == FRR_ADDR |-> (prdata & 32'hffffff88) == 32'h0)
		else $error("reserved frame rate bits not zero");
	a_unmapped_zero: assert property (rdDone && !mapped |-> prdata == 0)
		else $error("unmapped read not zero");
	a_frame_single: assert property (frameStart |=> !frameStart)
		else $error("frame pulse longer than one cycle");
	c_frame: cover property (frameStart);
	c_err: cover property (pready && pslverr);
	c_frr_read: cover property (rdDone && paddr == FRR_ADDR);
endmodule
bind lcdfr_frame_divider lcdfr_frame_divider_monitor u_mon (
	.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .frameStart(frameStart));

// >>> tb/lcd_frame_rate_divider_tb_top.sv
/* Self-checking bench: register access, frame and tap periods.
   Assumes the slave raises pready in the access phase; the external
   panel clock is made here at a tenth of sys_clk. */
module lcd_frame_rate_divider_tb_top import lcdfr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        extClock = 1'h0;
	logic        panelClk;
	logic        frameStart;
	logic [31:0] rdVal;
	logic        rdErr;
	logic [3:0]  extCnt = 4'h0;
	logic [31:0] n;
	int          errTotal = 0;
	int          samplesChecked = 0;
	lcdfr_frame_divider u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.extClock(extClock), .prescaledPanelClock(panelClk),
		.frameStart(frameStart));
	initial
	begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end
	// external clock, one rising edge every 10 cycles
	always @(posedge sys_clk)
	begin
		extCnt <= (extCnt == 4'h9) ? 4'h0 : extCnt + 4'h1;
		extClock <= extCnt < 4'h5;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		samplesChecked++;
		if (s !== x)
		begin
			errTotal++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		do
			@(posedge sys_clk);
		while (pready !== 1'h1);
		rdVal = prdata;
		rdErr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge sys_clk);
	endtask
	// interval to the next frame pulse or tap clock change
	task automatic period(input logic tap);
		logic p;
		repeat (3)
		begin
			n = 32'h0;
			p = panelClk;
			do
			begin
				@(posedge sys_clk);
				n++;
			end while (!(tap ? panelClk !== p : frameStart === 1'h1)
				&& n < 32'h7530);
		end
	endtask
	task automatic testRegs;
		apb(1'h0, FRR_ADDR, 32'h0);
		chk(rdVal, {24'h0, FRR_RESET});
		apb(1'h1, FRR_ADDR, 32'hffffffff);
		apb(1'h0, FRR_ADDR, 32'h0);
		chk(rdVal, 32'h77);
		apb(1'h1, 12'h3a4, 32'hffffffff);
		apb(1'h0, 12'h3a4, 32'h0);
		chk({rdErr, rdVal[30:0]}, 32'h80000000);
		$display("regs test done");
	endtask
	task automatic testReset;
		apb(1'h1, FRR_ADDR, 32'h55);
		apb(1'h0, FRR_ADDR, 32'h0);
		chk(rdVal, 32'h55);
		rst <= 1'h1;
		repeat (2) @(posedge sys_clk);
		chk({pready, pslverr, panelClk, frameStart}, 32'h0);
		chk(prdata, 32'h0);
		rst <= 1'h0;
		@(posedge sys_clk);
		apb(1'h0, FRR_ADDR, 32'h0);
		chk(rdVal, {24'h0, FRR_RESET});
		apb(1'h0, CTRL_ADDR, 32'h0);
		chk(rdVal, {29'h0, CTRL_RESET});
		$display("reset test done");
	endtask
	task automatic testDuty;
		for (int d = 0; d < 4; d++)
		begin
			apb(1'h1, CTRL_ADDR, 32'(d << 1));
			apb(1'h0, CTRL_ADDR, 32'h0);
			chk(rdVal, 32'(d << 1));
			apb(1'h1, FRR_ADDR, 32'h0);
			period(1'h0);
			chk(n, d == 2 ? 32'h60 : 32'h80);
			apb(1'h0, STAT_ADDR, 32'h0);
			chk(rdVal, {27'h0, panelClk, 4'h0});
		end
		$display("duty test done");
	endtask
	task automatic testDivide;
		apb(1'h1, CTRL_ADDR, 32'h2);
		for (int c = 0; c < 8; c++)
		begin
			apb(1'h1, FRR_ADDR, 32'(c));
			period(1'h0);
			chk(n, 32'(128 * (c + 1)));
		end
		$display("divide test done");
	endtask
	task automatic testTap;
		apb(1'h1, CTRL_ADDR, 32'h0);
		for (int p = 0; p < 8; p++)
		begin
			apb(1'h1, FRR_ADDR, 32'(p << 4));
			period(1'h1);
			chk(n, p == 0 ? 32'h10 : 32'(32 << p));
		end
		apb(1'h1, CTRL_ADDR, 32'h1);
		apb(1'h1, FRR_ADDR, 32'h0);
		period(1'h0);
		chk(n, 32'h500);
		$display("tap and source test done");
	endtask
	task automatic stopTest;
		$display("checks %0d mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rst = 1'h1;
		repeat (20) @(posedge sys_clk);
		rst <= 1'h0;
		@(posedge sys_clk);
		testRegs;
		testReset;
		testDuty;
		testDivide;
		testTap;
		stopTest;
	end
	initial
	begin
		#400000;
		errTotal++;
		stopTest;
	end
endmodule
